// ==== hdl/cfg_load_pkg.sv ====
// Shared constants and types for the parallel configuration load sequencer.
`default_nettype none
package cfg_load_pkg;
  localparam int SYS_CLK_MHZ    = 25;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LENGTH = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0c;
  localparam logic [7:0] OFS_CHKSUM = 8'h10;
  // Control field positions and the control and length reset values.
  localparam int CTRL_BUS16    = 0;
  localparam int CTRL_ENCRYPT  = 1;
  localparam int CTRL_COMPRESS = 2;
  localparam int CTRL_USER_CLK = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [31:0] LENGTH_RESET = 32'h0000_0000;
  // Status field positions.
  localparam int STAT_RATIO  = 8;
  localparam int STAT_PIN    = 16;
  localparam int STAT_REQ    = 17;
  localparam int STAT_DONE   = 18;
  // Times as printed and their cycle counts at the system clock.
  localparam int POR_FAST_MS     = 4;
  localparam int POR_STD_MS      = 100;
  localparam int STATUS_MIN_US   = 268;
  localparam int CD2UM_MIN_US    = 175;
  localparam int LOAD_CLK_MIN_NS = 8;
  localparam int CU_WAIT_NS      = 4 * LOAD_CLK_MIN_NS;
  localparam int INIT_CYCLES     = 17408;
  localparam int POR_FAST_CYC    = POR_FAST_MS * SYS_CLK_MHZ * 1000;
  localparam int POR_STD_CYC     = POR_STD_MS * SYS_CLK_MHZ * 1000;
  localparam int STATUS_MIN_CYC  = STATUS_MIN_US * SYS_CLK_MHZ;
  localparam int CD2UM_MIN_CYC   = CD2UM_MIN_US * SYS_CLK_MHZ;
  localparam int CU_WAIT_RAW     = (CU_WAIT_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int CU_WAIT_CYC     = (CU_WAIT_RAW < 1) ? 1 : CU_WAIT_RAW;

  typedef struct packed {
    logic user_clk;
    logic compress;
    logic encrypt;
    logic bus16;
  } ctrl_t;

  typedef enum logic [6:0] {
    ST_POR     = 7'h01,
    ST_RESET   = 7'h02,
    ST_RELEASE = 7'h04,
    ST_LOAD    = 7'h08,
    ST_CU_WAIT = 7'h10,
    ST_INIT    = 7'h20,
    ST_USER    = 7'h40
  } state_t;
endpackage : cfg_load_pkg
`default_nettype wire

// ==== hdl/parallel_config_load_sequencer.sv ====
// Configuration load sequencer with a Wishbone register slave.
// How it works
// RULE_01: 8-bit load: ratio 1, or 2 compressed.
// RULE_02: 16-bit load: ratio 1, 2 encrypted, 4 compressed.
// RULE_03: Host clock equals ratio times data rate.
// RULE_04: Request low pulls completion low within 600 ns.
// RULE_05: Request low pulls status low within 600 ns.
// RULE_06: Host holds request low at least 2 us.
// RULE_07: Status stays low 268 to 1506 us.
// RULE_08: Status released within 1506 us after request.
// RULE_09: Monitoring host waits 2 us after status.
// RULE_10: Blind host waits 1506 us after request.
// RULE_11: Load clock at most 125 MHz, 45% phases.
// RULE_12: Data captured on rising load clock edges.
// RULE_13: Internal oscillator: user mode 175 to 437 us.
// RULE_14: Initialization takes at least 17408 clock cycles.
// RULE_15: User clock enabled four load periods after completion.
// RULE_16: Power-on delay fast 4-12 ms, standard 100-300 ms.
// RULE_17: Host holds data across whole ratio group.
`default_nettype none
module parallel_config_load_sequencer #(
  parameter int POR_FAST     = cfg_load_pkg::POR_FAST_CYC,
  parameter int POR_STD      = cfg_load_pkg::POR_STD_CYC,
  parameter int STATUS_MIN   = cfg_load_pkg::STATUS_MIN_CYC,
  parameter int CD2UM_MIN    = cfg_load_pkg::CD2UM_MIN_CYC,
  parameter int INIT_CYC     = cfg_load_pkg::INIT_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC,
  input  wire logic        WB_STB,
  input  wire logic        WB_WE,
  input  wire logic [7:0]  WB_ADR,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK,
  input  wire logic        POR_STANDARD,
  input  wire logic        CFG_REQ_N,
  input  wire logic        STATUS_N_I,
  output logic             STATUS_N_O,
  output logic             STATUS_N_OE,
  input  wire logic        DONE_I,
  output logic             DONE_O,
  output logic             DONE_OE,
  input  wire logic        LOAD_CLK,
  input  wire logic [15:0] LOAD_DATA,
  input  wire logic        USER_INIT_CLK,
  output logic             USER_INIT_EN,
  output logic             USER_MODE
);

  function automatic logic [2:0] ratio_of(cfg_load_pkg::ctrl_t c);
    if (!c.bus16) begin
      return c.compress ? 3'h2 : 3'h1; // see RULE_01
    end
    if (c.compress) begin
      return 3'h4; // see RULE_02
    end
    return c.encrypt ? 3'h2 : 3'h1; // see RULE_02
  endfunction : ratio_of

  function automatic logic [31:0] to_gray(logic [31:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  function automatic logic [31:0] from_gray(logic [31:0] g);
    logic [31:0] b;
    b = g;
    for (int i = 30; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : from_gray

  function automatic logic [31:0] merge(logic [31:0] old,
                                        logic [31:0] dat,
                                        logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // System-domain registers.
  cfg_load_pkg::ctrl_t  ctrl;
  cfg_load_pkg::state_t state;
  cfg_load_pkg::state_t next_state;
  logic [31:0] length;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic        req_s1, req_s2;
  logic        stat_s1, stat_s2;
  logic        done_s1, done_s2;
  logic        strap_s1, strap_s2;
  logic        uclk_s1, uclk_s2, uclk_s3;
  logic [31:0] cnt_s1, cnt_s2;
  logic [15:0] chk_s1, chk_s2;

  // Link-domain registers and their reset from the system side.
  logic        link_run;
  logic [1:0]  phase;
  logic [31:0] lcount;
  logic [31:0] lgray;
  logic [15:0] lchk;

  // Synchronisers for the pins and the link count and checksum, on the system clock.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_s1   <= 1'b1;
      req_s2   <= 1'b1;
      stat_s1  <= 1'b1;
      stat_s2  <= 1'b1;
      done_s1  <= 1'b0;
      done_s2  <= 1'b0;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      uclk_s1  <= 1'b0;
      uclk_s2  <= 1'b0;
      uclk_s3  <= 1'b0;
      cnt_s1   <= 32'h0000_0000;
      cnt_s2   <= 32'h0000_0000;
      chk_s1   <= 16'h0000;
      chk_s2   <= 16'h0000;
    end else begin
      req_s1   <= CFG_REQ_N;
      req_s2   <= req_s1;
      stat_s1  <= STATUS_N_I;
      stat_s2  <= stat_s1;
      done_s1  <= DONE_I;
      done_s2  <= done_s1;
      strap_s1 <= POR_STANDARD;
      strap_s2 <= strap_s1;
      uclk_s1  <= USER_INIT_CLK;
      uclk_s2  <= uclk_s1;
      uclk_s3  <= uclk_s2;
      cnt_s1   <= lgray;
      cnt_s2   <= cnt_s1;
      chk_s1   <= lchk;
      chk_s2   <= chk_s1;
    end
  end

  wire         req_low   = !req_s2;
  wire         uclk_rise = uclk_s2 && !uclk_s3;
  wire  [31:0] words     = from_gray(cnt_s2);
  wire         all_in    = (length != 32'h0000_0000) && (words == length);
  wire  [31:0] por_cyc   = strap_s2 ? 32'(POR_STD) : 32'(POR_FAST);
  wire         in_st_init = (state == cfg_load_pkg::ST_INIT);
  wire         user_count = in_st_init && ctrl.user_clk;
  // The link side runs from load start until the next request.
  wire         link_on    = (next_state != cfg_load_pkg::ST_POR) &&
                            (next_state != cfg_load_pkg::ST_RESET) &&
                            (next_state != cfg_load_pkg::ST_RELEASE);

  // Sequencer.
  always_comb begin
    next_state = state;
    case (state)
      cfg_load_pkg::ST_POR: begin
        if (timer >= por_cyc) begin
          next_state = cfg_load_pkg::ST_RESET; // see RULE_16
        end
      end
      cfg_load_pkg::ST_RESET: begin
        if (!req_low && timer >= 32'(STATUS_MIN)) begin
          next_state = cfg_load_pkg::ST_RELEASE; // see RULE_07
        end
      end
      cfg_load_pkg::ST_RELEASE: begin
        // Another party may still hold the status line low.
        if (stat_s2) begin
          next_state = cfg_load_pkg::ST_LOAD; // see RULE_08
        end
      end
      cfg_load_pkg::ST_LOAD: begin
        if (all_in) begin
          next_state = ctrl.user_clk ? cfg_load_pkg::ST_CU_WAIT
                                     : cfg_load_pkg::ST_INIT;
        end
      end
      cfg_load_pkg::ST_CU_WAIT: begin
        if (timer >= 32'(cfg_load_pkg::CU_WAIT_CYC)) begin
          next_state = cfg_load_pkg::ST_INIT; // see RULE_15
        end
      end
      cfg_load_pkg::ST_INIT: begin
        if (ctrl.user_clk && timer >= 32'(INIT_CYC)) begin
          next_state = cfg_load_pkg::ST_USER; // see RULE_14
        end else if (!ctrl.user_clk && timer >= 32'(CD2UM_MIN)) begin
          next_state = cfg_load_pkg::ST_USER; // see RULE_13
        end
      end
      default: begin
        next_state = cfg_load_pkg::ST_USER;
      end
    endcase
    // A request restarts the cycle from any state past power-on.
    if (req_low && state != cfg_load_pkg::ST_POR) begin
      next_state = cfg_load_pkg::ST_RESET; // see RULE_04
    end
  end

  always_comb begin
    if (next_state != state) begin
      next_timer = 32'h0000_0000;
    end else if (user_count) begin
      next_timer = timer + {31'h0, uclk_rise}; // see RULE_14
    end else begin
      next_timer = timer + 32'h0000_0001;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state    <= cfg_load_pkg::ST_POR;
      timer    <= 32'h0000_0000;
      link_run <= 1'b0;
    end else begin
      state    <= next_state;
      timer    <= next_timer;
      link_run <= link_on;
    end
  end

  // Pin drivers follow the next state so a request acts in three edges.
  wire hold_status = (next_state == cfg_load_pkg::ST_POR) ||
                     (next_state == cfg_load_pkg::ST_RESET);
  wire hold_done   = hold_status ||
                     (next_state == cfg_load_pkg::ST_RELEASE) ||
                     (next_state == cfg_load_pkg::ST_LOAD);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      STATUS_N_O   <= 1'b0;
      STATUS_N_OE  <= 1'b1;
      DONE_O       <= 1'b0;
      DONE_OE      <= 1'b1;
      USER_INIT_EN <= 1'b0;
      USER_MODE    <= 1'b0;
    end else begin
      STATUS_N_O   <= 1'b0;
      STATUS_N_OE  <= hold_status; // see RULE_05
      DONE_O       <= 1'b0;
      DONE_OE      <= hold_done; // see RULE_04
      USER_INIT_EN <= ctrl.user_clk &&
                      (next_state == cfg_load_pkg::ST_INIT);
      USER_MODE    <= (next_state == cfg_load_pkg::ST_USER);
    end
  end

  // Wishbone slave: one wait state, unmapped reads return zero.
  wire        wb_req  = WB_CYC && WB_STB && !WB_ACK;
  wire        wr_ctrl = wb_req && WB_WE && (WB_ADR == cfg_load_pkg::OFS_CTRL);
  wire        wr_len  = wb_req && WB_WE &&
                        (WB_ADR == cfg_load_pkg::OFS_LENGTH);
  wire [31:0] ctrl_new = merge({28'h0, ctrl}, WB_DAT_I, WB_SEL);
  wire [31:0] stat_word = {13'h0, done_s2, req_low, stat_s2,
                           5'h0, ratio_of(ctrl), 1'b0, state};
  wire [31:0] rd_data =
    (WB_ADR == cfg_load_pkg::OFS_CTRL)   ? {28'h0, ctrl} :
    (WB_ADR == cfg_load_pkg::OFS_LENGTH) ? length :
    (WB_ADR == cfg_load_pkg::OFS_STATUS) ? stat_word :
    (WB_ADR == cfg_load_pkg::OFS_COUNT)  ? words :
    (WB_ADR == cfg_load_pkg::OFS_CHKSUM) ? {16'h0, chk_s2} :
    32'h0000_0000;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl     <= cfg_load_pkg::CTRL_RESET;
      length   <= cfg_load_pkg::LENGTH_RESET;
      WB_ACK   <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK   <= wb_req;
      WB_DAT_O <= wb_req ? rd_data : 32'h0000_0000;
      if (wr_ctrl) begin
        ctrl <= cfg_load_pkg::ctrl_t'(ctrl_new[3:0]);
      end
      if (wr_len) begin
        length <= merge(length, WB_DAT_I, WB_SEL);
      end
    end
  end

  // Link domain. The control bits and the length are quasi-static here:
  // software must not change them while a load is running. The load clock
  // may stand still, so nothing may wait for its edges to synchronise.
  // The reset is released while the host still holds the clock still
  // after status goes high, so its release needs no synchroniser.
  wire        link_rst_n = link_run;
  wire [2:0]  lratio  = ratio_of(ctrl);
  wire        lfull   = (length != 32'h0000_0000) && (lcount == length);
  wire        ltake   = (phase == 2'h0) && !lfull;
  wire [15:0] lword   = ctrl.bus16 ? LOAD_DATA
                                   : {8'h00, LOAD_DATA[7:0]};
  wire [31:0] lnext   = lcount + 32'h0000_0001;
  wire        lwrap   = ({1'b0, phase} == lratio - 3'h1);

  always_ff @(posedge LOAD_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      phase  <= 2'h0;
      lcount <= 32'h0000_0000;
      lgray  <= 32'h0000_0000;
      lchk   <= 16'h0000;
    end else begin
      // One word is taken per ratio group; the rest of the group's
      // edges only advance the phase.
      phase <= lwrap ? 2'h0 : phase + 2'h1; // see RULE_01
      if (ltake) begin
        lcount <= lnext; // see RULE_12
        lgray  <= to_gray(lnext);
        lchk   <= lchk ^ lword; // see RULE_12
      end
    end
  end

endmodule : parallel_config_load_sequencer
`default_nettype wire

// ==== verification/cfg_host.sv ====
// Behavioural configuration host: request pin, load clock and data.
`default_nettype none
module cfg_host (
  output logic        req_n,
  output logic        lclk,
  output logic [15:0] ldat,
  input  wire logic   status_w
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_n = 1'b1;
    lclk  = 1'b0;
    ldat  = 16'h5a5a;
  end
  function automatic logic [15:0] wd(input int i);
    return 16'h3c96 + 16'(i) * 16'h0b17;
  endfunction : wd
  // A blind host ignores the status pin and waits the full release time.
  task run(input int nw, input int r, input bit blind);
    int i;
    int k;
    req_n <= 1'b0;
    #2040;
    req_n <= 1'b1;
    if (blind) begin
      #1506000;
    end else begin
      while (status_w !== 1'b1) #40;
      #2040;
    end
    for (i = 0; i < nw; i++) begin
      ldat = wd(i);
      for (k = 0; k < r; k++) begin
        #8 lclk = 1'b1;
        #32 lclk = 1'b0;
        #24;
      end
    end
    // The clock stands still after a frame and the bus no longer holds data.
    ldat = ~ldat;
  endtask : run
endmodule : cfg_host
`default_nettype wire

// ==== verification/cfg_seq_assertions.sv ====
// Port-level timing checks for the configuration load sequencer.
`default_nettype none
module cfg_seq_chk #(
  parameter int STATUS_MIN = 10,
  parameter int CD2UM_MIN  = 10,
  parameter int INIT_CYC   = 8
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_ACK,
  input wire logic CFG_REQ_N,
  input wire logic STATUS_N_OE,
  input wire logic DONE_OE,
  input wire logic USER_INIT_CLK,
  input wire logic USER_INIT_EN,
  input wire logic USER_MODE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sc;
  logic [15:0] dc;
  logic [15:0] uc;
  logic        uq;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sc <= '0;
      dc <= '0;
      uc <= '0;
      uq <= 1'b0;
    end else begin
      sc <= STATUS_N_OE ? sc + 16'h1 : '0;
      dc <= DONE_OE ? '0 : dc + 16'h1;
      uq <= USER_INIT_CLK;
      uc <= !USER_INIT_EN ? '0 : uc + 16'(USER_INIT_CLK && !uq);
    end
  end
  a_done_on_req: assert property ($fell(CFG_REQ_N) |-> ##[1:15] DONE_OE)
    else $error("completion not pulled low in time");
  a_status_on_req: assert property ($fell(CFG_REQ_N) |-> ##[1:15] STATUS_N_OE)
    else $error("status not pulled low in time");
  // The request is synchronised first, so the pin low time starts 3 late.
  a_status_width: assert property ($fell(STATUS_N_OE) |-> sc >= STATUS_MIN - 3)
    else $error("status low pulse too short");
  a_release_after_req: assert property ($fell(STATUS_N_OE) |-> CFG_REQ_N && $past(CFG_REQ_N))
    else $error("status released while request low");
  a_user_delay: assert property ($rose(USER_MODE) |-> dc >= CD2UM_MIN)
    else $error("user mode too soon after completion");
  // One user clock edge may fall in the synchroniser's blind spot.
  a_init_count: assert property ($fell(USER_INIT_EN) |-> USER_MODE && uc >= INIT_CYC - 1)
    else $error("too few initialisation cycles");
  a_en_after_done: assert property ($rose(USER_INIT_EN) |-> !DONE_OE && !$past(DONE_OE))
    else $error("user clock enabled before completion");
  a_user_clean: assert property (USER_MODE |-> !DONE_OE && !STATUS_N_OE)
    else $error("pins held low in user mode");
  a_ack_single: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK ##1 !WB_ACK)
    else $error("bus answer not a single pulse");
  c_user: cover property ($rose(USER_MODE));
  c_user_clk: cover property ($rose(USER_INIT_EN));
  c_done: cover property ($fell(DONE_OE));
endmodule : cfg_seq_chk
bind parallel_config_load_sequencer cfg_seq_chk #(
  .STATUS_MIN(STATUS_MIN), .CD2UM_MIN(CD2UM_MIN), .INIT_CYC(INIT_CYC)
) chk (.SYS_CLK, .RST_N, .WB_CYC, .WB_STB, .WB_ACK, .CFG_REQ_N,
  .STATUS_N_OE, .DONE_OE, .USER_INIT_CLK, .USER_INIT_EN, .USER_MODE);
`default_nettype wire

// ==== verification/parallel_config_load_sequencer_tb_top.sv ====
// Self-checking bench for the configuration load sequencer.
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module parallel_config_load_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        SYS_CLK, RST_N, WB_CYC, WB_STB, WB_WE, WB_ACK;
  logic        POR_STANDARD, STATUS_N_O, STATUS_N_OE, DONE_O, DONE_OE;
  logic        USER_INIT_CLK, USER_INIT_EN, USER_MODE, CFG_REQ_N, LOAD_CLK;
  logic [7:0]  WB_ADR;
  logic [3:0]  WB_SEL;
  logic [31:0] WB_DAT_I, WB_DAT_O, rd;
  logic [15:0] LOAD_DATA;
  // Both pins have pull-ups, so a released pin reads high.
  wire         st_w = STATUS_N_OE ? STATUS_N_O : 1'b1;
  wire         dn_w = DONE_OE ? DONE_O : 1'b1;
  int          n_fail, n_compared, cyc_n;
  parallel_config_load_sequencer #(.POR_FAST(20), .POR_STD(40),
    .STATUS_MIN(10), .CD2UM_MIN(10), .INIT_CYC(8)) dut (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC(WB_CYC), .WB_STB(WB_STB),
    .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK), .POR_STANDARD(POR_STANDARD),
    .CFG_REQ_N(CFG_REQ_N), .STATUS_N_I(st_w), .STATUS_N_O(STATUS_N_O),
    .STATUS_N_OE(STATUS_N_OE), .DONE_I(dn_w), .DONE_O(DONE_O),
    .DONE_OE(DONE_OE), .LOAD_CLK(LOAD_CLK), .LOAD_DATA(LOAD_DATA),
    .USER_INIT_CLK(USER_INIT_CLK), .USER_INIT_EN(USER_INIT_EN),
    .USER_MODE(USER_MODE));
  cfg_host host (.req_n(CFG_REQ_N), .lclk(LOAD_CLK), .ldat(LOAD_DATA),
    .status_w(st_w));
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    USER_INIT_CLK = 1'b0;
    forever #100 USER_INIT_CLK = ~USER_INIT_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc_n++;
    // The blind host's long wait dominates the run time.
    if (cyc_n == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
          input logic [3:0] s);
    @(posedge SYS_CLK);
    WB_CYC <= 1'b1;
    WB_STB <= 1'b1;
    WB_WE <= we;
    WB_ADR <= a;
    WB_DAT_I <= d;
    WB_SEL <= s;
    do @(posedge SYS_CLK); while (WB_ACK !== 1'b1);
    rd = WB_DAT_O;
    WB_CYC <= 1'b0;
    WB_STB <= 1'b0;
  endtask : wb
  task do_reset(input logic std);
    @(posedge SYS_CLK);
    RST_N <= 1'b0;
    POR_STANDARD <= std;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
  endtask : do_reset
  task t_por;
    do_reset(1'b1);
    repeat (30) @(posedge SYS_CLK);
    wb(1'b0, cfg_load_pkg::OFS_STATUS, 32'h0, 4'hf);
    `CHK(rd[6:0], 7'h01)
    wb(1'b0, cfg_load_pkg::OFS_LENGTH, 32'h0, 4'hf);
    `CHK(rd, cfg_load_pkg::LENGTH_RESET)
    do_reset(1'b0);
    repeat (24) @(posedge SYS_CLK);
    wb(1'b0, cfg_load_pkg::OFS_STATUS, 32'h0, 4'hf);
    `CHK(rd[0], 1'b0)
    wb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
    wb(1'b0, 8'h40, 32'h0, 4'hf);
    `CHK(rd, 32'h0)
    wb(1'b1, cfg_load_pkg::OFS_CTRL, 32'hf, 4'he);
    wb(1'b0, cfg_load_pkg::OFS_CTRL, 32'h0, 4'hf);
    `CHK(rd[3:0], cfg_load_pkg::CTRL_RESET)
  endtask : t_por
  task t_load(input logic [3:0] c, input int len);
    int r;
    int i;
    logic [15:0] x;
    r = c[0] ? (c[2] ? 4 : c[1] ? 2 : 1) : (c[2] ? 2 : 1);
    wb(1'b1, cfg_load_pkg::OFS_CTRL, {28'h0, c}, 4'hf);
    wb(1'b1, cfg_load_pkg::OFS_LENGTH, 32'(len), 4'hf);
    wb(1'b0, cfg_load_pkg::OFS_STATUS, 32'h0, 4'hf);
    `CHK(rd[10:8], 3'(r))
    host.run(3, r, c == 4'hf);
    x = 16'h0;
    for (i = 0; i < len; i++) x ^= host.wd(i);
    if (!c[0]) x[15:8] = 8'h0;
    for (i = 0; i < 100 && DONE_OE !== 1'b0; i++) @(posedge SYS_CLK);
    `CHK(DONE_OE, 1'b0)
    `CHK({STATUS_N_O, DONE_O}, 2'b00)
    wb(1'b0, cfg_load_pkg::OFS_COUNT, 32'h0, 4'hf);
    `CHK(rd, 32'(len))
    wb(1'b0, cfg_load_pkg::OFS_CHKSUM, 32'h0, 4'hf);
    `CHK(rd[15:0], x)
    for (i = 0; i < 400 && USER_MODE !== 1'b1; i++) @(posedge SYS_CLK);
    `CHK(USER_MODE, 1'b1)
  endtask : t_load
  initial begin
    RST_N = 1'b0;
    POR_STANDARD = 1'b0;
    WB_CYC = 1'b0;
    WB_STB = 1'b0;
    WB_WE = 1'b0;
    WB_ADR = 8'h0;
    WB_SEL = 4'h0;
    WB_DAT_I = 32'h0;
    t_por();
    // Word count 2 of 3 sent checks that surplus words are ignored.
    for (int c = 0; c < 8; c++) t_load({c[1], c[2:0]}, (c == 5) ? 2 : 3);
    tally_and_finish();
  end
endmodule : parallel_config_load_sequencer_tb_top
`default_nettype wire
